// >>> verilog/cpusr_pkg.sv
/*
 * Shared constants of the core special register block: addresses in the
 * special-function space, reset values, status word field positions and
 * the arithmetic operation codes.
 * Assumes one core clock and one asynchronous active-low system reset.
 */
`default_nettype none

package cpusr_pkg;

   // Special-function addresses
   localparam logic [7:0] ADDR_STACK   = 8'h81;
   localparam logic [7:0] ADDR_PTR_HI  = 8'h83;
   localparam logic [7:0] ADDR_STATUS  = 8'hd0;
   localparam logic [7:0] ADDR_PRIMARY = 8'he0;
   localparam logic [7:0] ADDR_SECOND  = 8'hf0;

   // Values after reset
   localparam logic [7:0] RST_STACK    = 8'h07;
   localparam logic [7:0] RST_PTR_HI   = 8'h00;
   localparam logic [7:0] RST_STATUS   = 8'h00;
   localparam logic [7:0] RST_PRIMARY  = 8'h00;
   localparam logic [7:0] RST_SECOND   = 8'h00;
   localparam logic [7:0] RST_BANK     = 8'h00;
   localparam logic [7:0] RD_UNMAPPED  = 8'h00;

   // Status word fields
   localparam int CARRY_BIT  = 7;
   localparam int NIBBLE_BIT = 6;
   localparam int USER0_BIT  = 5;
   localparam int BANK_MSB   = 4;
   localparam int BANK_LSB   = 3;
   localparam int WRAP_BIT   = 2;
   localparam int USER1_BIT  = 1;
   localparam int PARITY_BIT = 0;

   // Largest product that fits the primary operand
   localparam logic [15:0] MUL_LIMIT = 16'h00ff;

   typedef enum logic [2:0] {
      OP_ADD,
      OP_ADDC,
      OP_SUBB,
      OP_MUL,
      OP_DIV
   } cpusr_op_t;

endpackage

`default_nettype wire

// >>> verilog/cpusr_alu.sv
/*
 * Combinational arithmetic unit: computes results and status flags for
 * add, add with carry, subtract with borrow, multiply and divide.
 * Assumes the caller registers the results and applies the flags only
 * when it issues an operation.
 */
`default_nettype none

module cpusr_alu (
   input  wire logic [7:0]         primary_i,
   input  wire logic [7:0]         second_i,
   input  wire logic [7:0]         operand_i,
   input  wire logic               carry_i,
   input  wire cpusr_pkg::cpusr_op_t op_i,
   output var  logic [7:0]         primary_res_o,
   output var  logic [7:0]         second_res_o,
   output var  logic               second_we_o,
   output var  logic               carry_o,
   output var  logic               nibble_o,
   output var  logic               wrap_o
);

   logic [8:0]  wide;
   logic [4:0]  nib;
   logic [15:0] prod;
   logic        cin;

   always_comb begin
      wide          = 9'h000;
      nib           = 5'h00;
      prod          = 16'h0000;
      cin           = (op_i != cpusr_pkg::OP_ADD) && carry_i;
      primary_res_o = primary_i;
      second_res_o  = second_i;
      second_we_o   = 1'b0;
      carry_o       = 1'b0;
      nibble_o      = 1'b0;
      wrap_o        = 1'b0;
      case (op_i)
         cpusr_pkg::OP_ADD,
         cpusr_pkg::OP_ADDC: begin
            wide = {1'b0, primary_i} + {1'b0, operand_i} + {8'h00, cin};
            nib  = {1'b0, primary_i[3:0]} + {1'b0, operand_i[3:0]}
                   + {4'h0, cin};
            primary_res_o = wide[7:0];
            carry_o  = wide[8];
            nibble_o = nib[4];
            wrap_o   = (primary_i[7] == operand_i[7])
                       && (wide[7] != primary_i[7]);
         end
         cpusr_pkg::OP_SUBB: begin
            wide = {1'b0, primary_i} - {1'b0, operand_i} - {8'h00, cin};
            nib  = {1'b0, primary_i[3:0]} - {1'b0, operand_i[3:0]}
                   - {4'h0, cin};
            primary_res_o = wide[7:0];
            carry_o  = wide[8];
            nibble_o = nib[4];
            wrap_o   = (primary_i[7] != operand_i[7])
                       && (wide[7] != primary_i[7]);
         end
         cpusr_pkg::OP_MUL: begin
            prod = {8'h00, primary_i} * {8'h00, second_i};
            primary_res_o = prod[7:0];
            second_res_o  = prod[15:8];
            second_we_o   = 1'b1;
            wrap_o = prod > cpusr_pkg::MUL_LIMIT;
         end
         cpusr_pkg::OP_DIV: begin
            // Operands are left untouched on a zero divisor
            if (second_i == 8'h00) begin
               wrap_o = 1'b1;
            end else begin
               primary_res_o = primary_i / second_i;
               second_res_o  = primary_i % second_i;
               second_we_o   = 1'b1;
            end
         end
         default: begin
            primary_res_o = primary_i;
         end
      endcase
   end

endmodule

`default_nettype wire

// >>> verilog/cpusr_regs.sv
/*
 * Core special registers: stack top pointer, upper byte of the indirect
 * pointer, primary and second operands and the status word, with byte
 * and bit access over the special-function port and core-side push, pop
 * and arithmetic strobes.
 * Assumes all strobes are synchronous to clk_i, one cycle each.
 */
// Contract
// - Upper pointer byte at 0x83, read/write, resets zero
// - Stack top pointer at 0x81 resets to 0x07
// - Push increments stack pointer before byte write
// - Primary operand at 0xe0, bit-addressable, resets zero
// - Second operand at 0xf0, bit-addressable, resets zero
// - Carry set on carry or borrow, else cleared
// - User flag bit 5 changed only by software
// - Bank select bits place working registers
// - Sign wrap flag on overflow, multiply product over 0xff, zero divide
`default_nettype none

module cpusr_regs (
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   input  wire logic [7:0]           sfr_addr_i,
   input  wire logic                 sfr_wr_i,
   input  wire logic [7:0]           sfr_wdata_i,
   input  wire logic                 sfr_rd_i,
   input  wire logic                 bit_wr_i,
   input  wire logic [7:0]           bit_addr_i,
   input  wire logic                 bit_val_i,
   input  wire logic                 push_i,
   input  wire logic                 pop_i,
   input  wire logic                 alu_go_i,
   input  wire cpusr_pkg::cpusr_op_t alu_op_i,
   input  wire logic [7:0]           alu_operand_i,
   output var  logic [7:0]           sfr_rdata_o,
   output var  logic [7:0]           stack_top_o,
   output var  logic [7:0]           pointer_upper_o,
   output var  logic [7:0]           primary_o,
   output var  logic [7:0]           second_o,
   output var  logic [7:0]           status_o,
   output var  logic [7:0]           bank_base_o
);

   logic [7:0] stack_r,   stack_nxt;
   logic [7:0] ptr_hi_r,  ptr_hi_nxt;
   logic [7:0] primary_r, primary_nxt;
   logic [7:0] second_r,  second_nxt;
   logic [7:0] status_r,  status_nxt;
   logic [7:0] bank_r,    bank_nxt;
   logic [7:0] rdata_r,   rdata_nxt;
   logic [7:0] alu_primary;
   logic [7:0] alu_second;
   logic       alu_second_we;
   logic       alu_carry;
   logic       alu_nibble;
   logic       alu_wrap;

   function automatic logic [7:0] put_bit(input logic [7:0] v,
                                          input logic [2:0] idx,
                                          input logic       val);
      logic [7:0] r;
      r      = v;
      r[idx] = val;
      return r;
   endfunction

   function automatic logic bit_hit(input logic [7:0] baddr,
                                    input logic [7:0] base);
      return baddr[7:3] == base[7:3];
   endfunction

   ////////////////////////////////////////////////////////////////////////

   cpusr_alu cpusr_alu_inst (
      .primary_i     (primary_r),
      .second_i      (second_r),
      .operand_i     (alu_operand_i),
      .carry_i       (status_r[cpusr_pkg::CARRY_BIT]),
      .op_i          (alu_op_i),
      .primary_res_o (alu_primary),
      .second_res_o  (alu_second),
      .second_we_o   (alu_second_we),
      .carry_o       (alu_carry),
      .nibble_o      (alu_nibble),
      .wrap_o        (alu_wrap)
   );

   ////////////////////////////////////////////////////////////////////////

   always_comb begin
      stack_nxt   = stack_r;
      ptr_hi_nxt  = ptr_hi_r;
      primary_nxt = primary_r;
      second_nxt  = second_r;
      status_nxt  = status_r;
      rdata_nxt   = cpusr_pkg::RD_UNMAPPED;
      if (sfr_wr_i) begin
         if (sfr_addr_i == cpusr_pkg::ADDR_STACK) begin
            stack_nxt = sfr_wdata_i;
         end else if (sfr_addr_i == cpusr_pkg::ADDR_PTR_HI) begin
            ptr_hi_nxt = sfr_wdata_i;
         end else if (sfr_addr_i == cpusr_pkg::ADDR_STATUS) begin
            status_nxt = sfr_wdata_i;
         end else if (sfr_addr_i == cpusr_pkg::ADDR_PRIMARY) begin
            primary_nxt = sfr_wdata_i;
         end else if (sfr_addr_i == cpusr_pkg::ADDR_SECOND) begin
            second_nxt = sfr_wdata_i;
         end
      end
      if (bit_wr_i) begin
         if (bit_hit(bit_addr_i, cpusr_pkg::ADDR_STATUS)) begin
            status_nxt = put_bit(status_nxt, bit_addr_i[2:0], bit_val_i);
         end else if (bit_hit(bit_addr_i, cpusr_pkg::ADDR_PRIMARY)) begin
            primary_nxt = put_bit(primary_nxt, bit_addr_i[2:0],
                                  bit_val_i);
         end else if (bit_hit(bit_addr_i, cpusr_pkg::ADDR_SECOND)) begin
            second_nxt = put_bit(second_nxt, bit_addr_i[2:0],
                                 bit_val_i);
         end
      end
      // Push bumps first, so the core stores at the new top
      if (push_i && !pop_i) begin
         stack_nxt = stack_nxt + 8'h01;
      end else if (pop_i && !push_i) begin
         stack_nxt = stack_nxt - 8'h01;
      end
      // Hardware flags win over a same-cycle software write
      if (alu_go_i) begin
         primary_nxt = alu_primary;
         if (alu_second_we) begin
            second_nxt = alu_second;
         end
         status_nxt[cpusr_pkg::CARRY_BIT]  = alu_carry;
         status_nxt[cpusr_pkg::NIBBLE_BIT] = alu_nibble;
         status_nxt[cpusr_pkg::WRAP_BIT]   = alu_wrap;
      end
      // Parity is read-only and always tracks the primary operand
      status_nxt[cpusr_pkg::PARITY_BIT] = ^primary_nxt;
      bank_nxt = {3'h0, status_nxt[cpusr_pkg::BANK_MSB:cpusr_pkg::BANK_LSB],
                  3'h0};
      if (sfr_rd_i) begin
         if (sfr_addr_i == cpusr_pkg::ADDR_STACK) begin
            rdata_nxt = stack_r;
         end else if (sfr_addr_i == cpusr_pkg::ADDR_PTR_HI) begin
            rdata_nxt = ptr_hi_r;
         end else if (sfr_addr_i == cpusr_pkg::ADDR_STATUS) begin
            rdata_nxt = status_r;
         end else if (sfr_addr_i == cpusr_pkg::ADDR_PRIMARY) begin
            rdata_nxt = primary_r;
         end else if (sfr_addr_i == cpusr_pkg::ADDR_SECOND) begin
            rdata_nxt = second_r;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         stack_r   <= cpusr_pkg::RST_STACK;
         ptr_hi_r  <= cpusr_pkg::RST_PTR_HI;
         primary_r <= cpusr_pkg::RST_PRIMARY;
         second_r  <= cpusr_pkg::RST_SECOND;
         status_r  <= cpusr_pkg::RST_STATUS;
         bank_r    <= cpusr_pkg::RST_BANK;
         rdata_r   <= cpusr_pkg::RD_UNMAPPED;
      end else begin
         stack_r   <= stack_nxt;
         ptr_hi_r  <= ptr_hi_nxt;
         primary_r <= primary_nxt;
         second_r  <= second_nxt;
         status_r  <= status_nxt;
         bank_r    <= bank_nxt;
         rdata_r   <= rdata_nxt;
      end
   end

   assign sfr_rdata_o     = rdata_r;
   assign stack_top_o     = stack_r;
   assign pointer_upper_o = ptr_hi_r;
   assign primary_o       = primary_r;
   assign second_o        = second_r;
   assign status_o        = status_r;
   assign bank_base_o     = bank_r;

   ////////////////////////////////////////////////////////////////////////

   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);

   a_ptr_hi_write: assert property (
      sfr_wr_i && sfr_addr_i == cpusr_pkg::ADDR_PTR_HI
      |=> pointer_upper_o == $past(sfr_wdata_i))
      else $error("upper pointer byte write lost");

   a_ptr_hi_read: assert property (
      sfr_rd_i && sfr_addr_i == cpusr_pkg::ADDR_PTR_HI
      |=> sfr_rdata_o == $past(pointer_upper_o))
      else $error("upper pointer byte read wrong");

   a_stack_reset: assert property (
      $rose(nrst_i) |-> stack_top_o == cpusr_pkg::RST_STACK)
      else $error("stack pointer not 0x07 after reset");

   a_push_incr: assert property (
      push_i && !pop_i
      && !(sfr_wr_i && sfr_addr_i == cpusr_pkg::ADDR_STACK)
      |=> stack_top_o == $past(stack_top_o) + 8'h01)
      else $error("push did not increment stack pointer");

   a_primary_bit: assert property (
      bit_wr_i && bit_hit(bit_addr_i, cpusr_pkg::ADDR_PRIMARY)
      && !alu_go_i && !sfr_wr_i
      |=> primary_o[$past(bit_addr_i[2:0])] == $past(bit_val_i)
          && status_o[cpusr_pkg::PARITY_BIT] == ^primary_o)
      else $error("primary operand bit write lost");

   a_second_write: assert property (
      sfr_wr_i && sfr_addr_i == cpusr_pkg::ADDR_SECOND && !bit_wr_i
      && !alu_go_i
      |=> second_o == $past(sfr_wdata_i))
      else $error("second operand write lost");

   a_carry_add: assert property (
      alu_go_i && alu_op_i == cpusr_pkg::OP_ADD
      |=> status_o[cpusr_pkg::CARRY_BIT] ==
          (({1'b0, $past(primary_o)} + {1'b0, $past(alu_operand_i)})
           > 9'h0ff))
      else $error("carry wrong after add");

   a_user_flag: assert property (
      !(sfr_wr_i && sfr_addr_i == cpusr_pkg::ADDR_STATUS)
      && !(bit_wr_i && bit_hit(bit_addr_i, cpusr_pkg::ADDR_STATUS))
      |=> $stable(status_o[cpusr_pkg::USER0_BIT]))
      else $error("user flag changed by hardware");

   a_nibble_sub: assert property (
      alu_go_i && alu_op_i == cpusr_pkg::OP_SUBB
      && !status_o[cpusr_pkg::CARRY_BIT]
      |=> status_o[cpusr_pkg::NIBBLE_BIT] ==
          ($past(primary_o[3:0]) < $past(alu_operand_i[3:0])))
      else $error("nibble borrow wrong after subtract");

   a_bank_base: assert property (
      bank_base_o == {3'h0,
                      status_o[cpusr_pkg::BANK_MSB:cpusr_pkg::BANK_LSB],
                      3'h0})
      else $error("bank base does not follow bank select");

   a_mul_wrap: assert property (
      alu_go_i && alu_op_i == cpusr_pkg::OP_MUL
      |=> status_o[cpusr_pkg::WRAP_BIT] ==
          (({8'h00, $past(primary_o)} * {8'h00, $past(second_o)})
           > 16'h00ff) && !status_o[cpusr_pkg::CARRY_BIT])
      else $error("wrap flag wrong after multiply");

   a_div_zero: assert property (
      alu_go_i && alu_op_i == cpusr_pkg::OP_DIV && second_o == 8'h00
      && !sfr_wr_i && !bit_wr_i
      |=> status_o[cpusr_pkg::WRAP_BIT] && $stable(primary_o))
      else $error("zero divide not flagged");

endmodule

`default_nettype wire

// >>> verif/test_cpu_core_special_registers.sv
/*
 * Self-checking bench for the core special registers: reset values,
 * byte and bit access, stack push and pop, arithmetic flags and bank map.
 * Assumes cpusr_pkg is compiled first and cpusr_regs is its only design.
 */
`default_nettype none

module test_cpu_core_special_registers;
   timeunit 1ns;
   timeprecision 100ps;

   logic                 clk_i, nrst_i, sfr_wr_i, sfr_rd_i, bit_wr_i;
   logic                 bit_val_i, push_i, pop_i, alu_go_i;
   logic [7:0]           sfr_addr_i, sfr_wdata_i, bit_addr_i, alu_operand_i;
   cpusr_pkg::cpusr_op_t alu_op_i, s_op;
   logic [7:0]           sfr_rdata_o, stack_top_o, pointer_upper_o;
   logic [7:0]           primary_o, second_o, status_o, bank_base_o;
   logic                 s_wr, s_rd, s_bw, s_bv, s_ps, s_pp, s_go, rd_seen;
   logic [7:0]           s_addr, s_wd, s_ba, s_opd;
   logic [7:0]           m_stk, m_phi, m_pri, m_sec, m_sw;
   logic [7:0]           exp_q[$];
   logic [7:0]           regs[4];
   int                   fails, n_tests, seed_init;

   cpusr_regs cpusr_regs_inst (
      .clk_i(clk_i), .nrst_i(nrst_i), .sfr_addr_i(sfr_addr_i),
      .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i),
      .bit_wr_i(bit_wr_i), .bit_addr_i(bit_addr_i), .bit_val_i(bit_val_i),
      .push_i(push_i), .pop_i(pop_i), .alu_go_i(alu_go_i),
      .alu_op_i(alu_op_i), .alu_operand_i(alu_operand_i),
      .sfr_rdata_o(sfr_rdata_o), .stack_top_o(stack_top_o),
      .pointer_upper_o(pointer_upper_o), .primary_o(primary_o),
      .second_o(second_o), .status_o(status_o), .bank_base_o(bank_base_o)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop;
      if (fails == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic check8(input logic [7:0] got, input logic [7:0] exp,
                         input string what);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // Staged request goes out once per cycle, so no input moves twice
   task automatic step;
      @(posedge clk_i);
      #1;
      sfr_wr_i = s_wr;
      sfr_rd_i = s_rd;
      bit_wr_i = s_bw;
      bit_val_i = s_bv;
      push_i = s_ps;
      pop_i = s_pp;
      alu_go_i = s_go;
      alu_op_i = s_op;
      sfr_addr_i = s_addr;
      sfr_wdata_i = s_wd;
      bit_addr_i = s_ba;
      alu_operand_i = s_opd;
      {s_wr, s_rd, s_bw, s_ps, s_pp, s_go} = 6'h00;
   endtask

   function automatic logic [7:0] mread(input logic [7:0] a);
      case (a)
         cpusr_pkg::ADDR_STACK:   return m_stk;
         cpusr_pkg::ADDR_PTR_HI:  return m_phi;
         cpusr_pkg::ADDR_STATUS:  return {m_sw[7:1], ^m_pri};
         cpusr_pkg::ADDR_PRIMARY: return m_pri;
         cpusr_pkg::ADDR_SECOND:  return m_sec;
         default:                 return cpusr_pkg::RD_UNMAPPED;
      endcase
   endfunction

   task automatic rd(input logic [7:0] a);
      s_rd = 1'b1;
      s_addr = a;
      exp_q.push_back(mread(a));
      step;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      s_wr = 1'b1;
      s_addr = a;
      s_wd = d;
      case (a)
         cpusr_pkg::ADDR_STACK:   m_stk = d;
         cpusr_pkg::ADDR_PTR_HI:  m_phi = d;
         cpusr_pkg::ADDR_STATUS:  m_sw = d;
         cpusr_pkg::ADDR_PRIMARY: m_pri = d;
         cpusr_pkg::ADDR_SECOND:  m_sec = d;
         default: ;
      endcase
      step;
   endtask

   task automatic bitw(input logic [7:0] a, input logic [2:0] i,
                       input logic v);
      s_bw = 1'b1;
      s_ba = {a[7:3], i};
      s_bv = v;
      if (a == cpusr_pkg::ADDR_STATUS && i != 3'h0) m_sw[i] = v;
      if (a == cpusr_pkg::ADDR_PRIMARY) m_pri[i] = v;
      if (a == cpusr_pkg::ADDR_SECOND) m_sec[i] = v;
      step;
   endtask

   task automatic stk(input logic ps, input logic pp);
      s_ps = ps;
      s_pp = pp;
      m_stk = m_stk + 8'(ps && !pp) - 8'(pp && !ps);
      step;
   endtask

   task automatic alu(input cpusr_pkg::cpusr_op_t op, input logic [7:0] d);
      logic [8:0]  s;
      logic [15:0] p;
      logic        ci, n, w;
      s_go = 1'b1;
      s_op = op;
      s_opd = d;
      ci = m_sw[7] && op != cpusr_pkg::OP_ADD;
      n = 1'b0;
      w = 1'b0;
      s = 9'h000;
      if (op == cpusr_pkg::OP_SUBB) begin
         s = {1'b0, m_pri} - {1'b0, d} - 9'(ci);
         n = {1'b0, m_pri[3:0]} < {1'b0, d[3:0]} + 5'(ci);
         w = (m_pri[7] != d[7]) && (s[7] != m_pri[7]);
         m_pri = s[7:0];
      end else if (op == cpusr_pkg::OP_MUL) begin
         p = 16'(m_pri) * 16'(m_sec);
         w = p > cpusr_pkg::MUL_LIMIT;
         {m_sec, m_pri} = p;
      end else if (op == cpusr_pkg::OP_DIV) begin
         w = m_sec == 8'h00;
         if (!w) {m_pri, m_sec} = {m_pri / m_sec, m_pri % m_sec};
      end else begin
         s = {1'b0, m_pri} + {1'b0, d} + 9'(ci);
         n = {1'b0, m_pri[3:0]} + {1'b0, d[3:0]} + 5'(ci) > 5'h0f;
         w = (m_pri[7] == d[7]) && (s[7] != m_pri[7]);
         m_pri = s[7:0];
      end
      {m_sw[7], m_sw[6], m_sw[2]} = {s[8], n, w};
      step;
   endtask

   task automatic chk_all;
      step;
      check8(stack_top_o, m_stk, "stack top");
      check8(pointer_upper_o, m_phi, "pointer upper");
      check8(primary_o, m_pri, "primary");
      check8(second_o, m_sec, "second");
      check8(status_o, {m_sw[7:1], ^m_pri}, "status");
      check8(bank_base_o, {3'h0, m_sw[4:3], 3'h0}, "bank base");
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Read data stands one cycle, so it is taken at the falling edge
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) rd_seen <= 1'b0;
      else rd_seen <= sfr_rd_i;
   end

   always @(negedge clk_i) begin
      if (rd_seen && exp_q.size() == 0) begin
         fails++;
         $display("BAD %0t read data with nothing expected", $time);
      end else if (rd_seen) begin
         check8(sfr_rdata_o, exp_q.pop_front(), "read data");
      end
   end

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   initial begin
      #100000;
      fails++;
      report_and_stop;
   end

   initial begin
      seed_init = $urandom(39);
      {sfr_wr_i, sfr_rd_i, bit_wr_i, bit_val_i} = 4'h0;
      {push_i, pop_i, alu_go_i, nrst_i} = 4'h0;
      {sfr_addr_i, sfr_wdata_i, bit_addr_i, alu_operand_i} = 32'h0;
      alu_op_i = cpusr_pkg::OP_ADD;
      s_op = cpusr_pkg::OP_ADD;
      {s_wr, s_rd, s_bw, s_bv, s_ps, s_pp, s_go} = 7'h00;
      {s_addr, s_wd, s_ba, s_opd} = 32'h0;
      m_stk = cpusr_pkg::RST_STACK;
      {m_phi, m_pri, m_sec, m_sw} = 32'h0;
      regs = '{cpusr_pkg::ADDR_STACK, cpusr_pkg::ADDR_PTR_HI,
               cpusr_pkg::ADDR_PRIMARY, cpusr_pkg::ADDR_SECOND};
      repeat (20) @(posedge clk_i);
      #1;
      nrst_i = 1'b1;
      chk_all;
      rd(cpusr_pkg::ADDR_STATUS);
      rd(8'h82);
      for (int i = 0; i < 4; i++) rd(regs[i]);
      for (int i = 0; i < 16; i++) begin
         wr(regs[i % 4], 8'($urandom));
         rd(regs[i % 4]);
      end
      wr(8'h85, 8'($urandom));
      rd(8'h85);
      chk_all;
      // Wrap at the top of the address space, then pop and cancel
      wr(cpusr_pkg::ADDR_STACK, 8'hfe);
      stk(1'b1, 1'b0);
      stk(1'b1, 1'b0);
      rd(cpusr_pkg::ADDR_STACK);
      stk(1'b0, 1'b1);
      stk(1'b1, 1'b1);
      chk_all;
      for (int i = 0; i < 8; i++) begin
         bitw(cpusr_pkg::ADDR_PRIMARY, 3'(i), 1'($urandom));
         bitw(cpusr_pkg::ADDR_SECOND, 3'(i), 1'($urandom));
         bitw(cpusr_pkg::ADDR_STATUS, 3'(i), 1'($urandom));
      end
      chk_all;
      for (int k = 0; k < 4; k++) begin
         wr(cpusr_pkg::ADDR_STATUS, {3'h1, 2'(k), 3'h3});
         chk_all;
      end
      wr(cpusr_pkg::ADDR_PRIMARY, 8'h0f);
      alu(cpusr_pkg::OP_ADD, 8'h01);
      wr(cpusr_pkg::ADDR_SECOND, 8'h00);
      alu(cpusr_pkg::OP_DIV, 8'h00);
      chk_all;
      for (int i = 0; i < 80; i++) begin
         if (i % 3 == 0) wr(cpusr_pkg::ADDR_PRIMARY, 8'($urandom));
         if (i % 4 == 0) wr(cpusr_pkg::ADDR_SECOND, 8'($urandom_range(20)));
         alu(cpusr_pkg::cpusr_op_t'(3'($urandom_range(4))), 8'($urandom));
         chk_all;
      end
      rd(cpusr_pkg::ADDR_STATUS);
      repeat (3) step;
      check8(8'(exp_q.size()), 8'h00, "reads left unanswered");
      report_and_stop;
   end

endmodule

`default_nettype wire
